// ==== core/tbc_pkg.sv ====
/*
 * tbc_pkg: shared widths, state codes and carrier structs of the
 * table-branch and conditional-block unit.
 * assumes a 32-bit byte address space and a 4-bit condition flag word.
 */
`default_nettype none
package tbc_pkg;
    localparam int ADDR_W      = 32;
    localparam int FLAG_W      = 4;
    localparam int COND_W      = 4;
    localparam int IT_LEN_W    = 3;
    localparam int IT_MAX_LEN  = 4;
    localparam int ENTRY_W     = 16;
    localparam int BYTE_W      = 8;
    localparam int IDX_SHIFT   = 1;   // halfword index scale
    localparam int OFS_SHIFT   = 1;   // entry doubling
    localparam int CBR_SHORT_W = 9;   // conditional branch reach outside a block
    localparam int CBR_LONG_W  = 21;  // conditional branch reach inside a block
    localparam logic [ADDR_W-1:0]   ADDR_RST  = 32'h0000_0000;
    localparam logic [FLAG_W-1:0]   FLAGS_RST = 4'h0;
    localparam logic [COND_W-1:0]   COND_RST  = 4'h0;
    localparam logic [IT_LEN_W-1:0] IT_NONE   = 3'h0;
    localparam logic [IT_LEN_W-1:0] IT_LAST   = 3'h1;

    typedef enum logic [0:0] {
        TBC_IDLE  = 1'b0,
        TBC_FETCH = 1'b1
    } tbc_state_t;

    typedef struct packed {
        logic              halfword;    // table_branch_halfword when set
        logic              base_is_pc;
        logic              base_is_sp;
        logic              index_is_sp;
        logic              index_is_pc;
        logic [ADDR_W-1:0] table_base_register;
        logic [ADDR_W-1:0] table_index_register;
        logic [ADDR_W-1:0] next_addr;   // byte after the table branch
    } tbc_req_t;

    typedef struct packed {
        logic [CBR_LONG_W-1:0] offset;  // signed byte offset
        logic [ADDR_W-1:0]     next_addr;
    } tbc_cbr_t;
endpackage
`default_nettype wire

// ==== core/tbc_table_branch.sv ====
/*
 * tbc_table_branch: executes table_branch_byte / table_branch_halfword,
 * tracks the if_then_block_prefix window, resolves conditional_branch
 * targets and holds the condition flags.
 * assumes a memory port returning the addressed byte or halfword in the
 * low lanes of i_mem_rdata, held stable with i_mem_ack; one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tbc_table_branch (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rstn,
    input  wire logic                         i_tb_valid,
    output logic                              o_tb_ready,
    input  wire tbc_pkg::tbc_req_t            i_tb_req,
    output logic                              o_mem_req,
    output logic [tbc_pkg::ADDR_W-1:0]        o_mem_addr,
    output logic                              o_mem_half,
    input  wire logic                         i_mem_ack,
    input  wire logic [tbc_pkg::ENTRY_W-1:0]  i_mem_rdata,
    output logic                              o_br_valid,
    output logic [tbc_pkg::ADDR_W-1:0]        o_br_target,
    output logic                              o_usage_err,
    input  wire logic                         i_it_valid,
    input  wire logic [tbc_pkg::IT_LEN_W-1:0] i_it_len,
    input  wire logic [tbc_pkg::COND_W-1:0]   i_it_cond,
    input  wire logic                         i_retire,
    output logic                              o_in_it_block,
    output logic [tbc_pkg::COND_W-1:0]        o_it_cond,
    input  wire logic                         i_cbr_valid,
    input  wire tbc_pkg::tbc_cbr_t            i_cbr,
    output logic                              o_cbr_valid,
    output logic [tbc_pkg::ADDR_W-1:0]        o_cbr_target,
    input  wire logic                         i_flags_we,
    input  wire logic [tbc_pkg::FLAG_W-1:0]   i_flags,
    output logic [tbc_pkg::FLAG_W-1:0]        o_flags
);
    localparam int                AW         = tbc_pkg::ADDR_W;
    localparam int                LW         = tbc_pkg::IT_LEN_W;
    // clamp limit for the block length; a longer prefix acts as a full block
    localparam logic [LW-1:0]     IT_LEN_MAX = LW'(tbc_pkg::IT_MAX_LEN);

    ////////////////////////////////////////////////////////////////////////////
    // table branch engine
    tbc_pkg::tbc_state_t           state_r, state_nxt;
    logic [AW-1:0]                 addr_r, addr_nxt;
    logic [AW-1:0]                 next_r, next_nxt;
    logic                          half_r, half_nxt;
    logic                          brv_r, brv_nxt;
    logic [AW-1:0]                 tgt_r, tgt_nxt;
    logic                          err_r, err_nxt;
    logic [AW-1:0]                 tbl_start;
    logic [AW-1:0]                 tbl_ofs;
    logic [AW-1:0]                 entry_ext;
    logic                          take;
    logic [tbc_pkg::IT_LEN_W-1:0]  it_left_r, it_left_nxt;

    assign o_tb_ready = (state_r == tbc_pkg::TBC_IDLE);
    assign take       = i_tb_valid && o_tb_ready;

    always_comb begin
        tbl_start = i_tb_req.base_is_pc ? i_tb_req.next_addr
                                        : i_tb_req.table_base_register;
        tbl_ofs   = i_tb_req.halfword
                  ? (i_tb_req.table_index_register << tbc_pkg::IDX_SHIFT)
                  : i_tb_req.table_index_register;
        // unsigned entry, upper lanes forced to zero
        entry_ext = half_r ? AW'(i_mem_rdata)
                           : AW'(i_mem_rdata[tbc_pkg::BYTE_W-1:0]);
        state_nxt = state_r;
        addr_nxt  = addr_r;
        next_nxt  = next_r;
        half_nxt  = half_r;
        tgt_nxt   = tgt_r;
        brv_nxt   = 1'b0;
        err_nxt   = 1'b0;
        unique case (state_r)
            tbc_pkg::TBC_IDLE: begin
                if (take) begin
                    state_nxt = tbc_pkg::TBC_FETCH;
                    addr_nxt  = tbl_start + tbl_ofs;
                    next_nxt  = i_tb_req.next_addr;
                    half_nxt  = i_tb_req.halfword;
                    // misuse is still executed; the flag only reports it
                    err_nxt   = i_tb_req.base_is_sp || i_tb_req.index_is_sp
                             || i_tb_req.index_is_pc
                             || (it_left_r != tbc_pkg::IT_NONE
                                 && it_left_r != tbc_pkg::IT_LAST);
                end
            end
            tbc_pkg::TBC_FETCH: begin
                if (i_mem_ack) begin
                    state_nxt = tbc_pkg::TBC_IDLE;
                    brv_nxt   = 1'b1;
                    tgt_nxt   = next_r + (entry_ext << tbc_pkg::OFS_SHIFT);
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= tbc_pkg::TBC_IDLE;
            addr_r  <= tbc_pkg::ADDR_RST;
            next_r  <= tbc_pkg::ADDR_RST;
            half_r  <= 1'b0;
            brv_r   <= 1'b0;
            tgt_r   <= tbc_pkg::ADDR_RST;
            err_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            next_r  <= next_nxt;
            half_r  <= half_nxt;
            brv_r   <= brv_nxt;
            tgt_r   <= tgt_nxt;
            err_r   <= err_nxt;
        end
    end

    assign o_mem_req   = (state_r == tbc_pkg::TBC_FETCH);
    assign o_mem_addr  = addr_r;
    assign o_mem_half  = half_r;
    assign o_br_valid  = brv_r;
    assign o_br_target = tgt_r;
    assign o_usage_err = err_r;

    ////////////////////////////////////////////////////////////////////////////
    // conditional block window and conditional branch reach
    logic [tbc_pkg::COND_W-1:0] cond_r, cond_nxt;
    logic                       cbv_r, cbv_nxt;
    logic [AW-1:0]              cbt_r, cbt_nxt;
    logic [AW-1:0]              cbr_ofs;

    always_comb begin
        it_left_nxt = it_left_r;
        cond_nxt    = cond_r;
        // a new prefix wins over a retire in the same cycle
        if (i_it_valid) begin
            it_left_nxt = (i_it_len > IT_LEN_MAX) ? IT_LEN_MAX : i_it_len;
            cond_nxt    = i_it_cond;
        end else if (i_retire && it_left_r != tbc_pkg::IT_NONE) begin
            it_left_nxt = it_left_r - tbc_pkg::IT_LAST;
        end
        cbr_ofs = (it_left_r != tbc_pkg::IT_NONE)
                ? AW'(signed'(i_cbr.offset))
                : AW'(signed'(i_cbr.offset[tbc_pkg::CBR_SHORT_W-1:0]));
        cbv_nxt = i_cbr_valid;
        cbt_nxt = i_cbr_valid ? i_cbr.next_addr + cbr_ofs : cbt_r;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            it_left_r <= tbc_pkg::IT_NONE;
            cond_r    <= tbc_pkg::COND_RST;
            cbv_r     <= 1'b0;
            cbt_r     <= tbc_pkg::ADDR_RST;
        end else begin
            it_left_r <= it_left_nxt;
            cond_r    <= cond_nxt;
            cbv_r     <= cbv_nxt;
            cbt_r     <= cbt_nxt;
        end
    end

    assign o_in_it_block = (it_left_r != tbc_pkg::IT_NONE);
    assign o_it_cond     = cond_r;
    assign o_cbr_valid   = cbv_r;
    assign o_cbr_target  = cbt_r;

    ////////////////////////////////////////////////////////////////////////////
    // condition flags: only an explicit writer changes them
    logic [tbc_pkg::FLAG_W-1:0] flags_r, flags_nxt;

    always_comb begin
        flags_nxt = i_flags_we ? i_flags : flags_r;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_r <= tbc_pkg::FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign o_flags = flags_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_byte_target: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state_r == tbc_pkg::TBC_FETCH && i_mem_ack && !half_r) |=>
        o_br_valid && o_br_target == $past(next_r) + {$past(i_mem_rdata[7:0]), 1'b0})
        else $error("byte table target wrong");
    chk_half_target: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state_r == tbc_pkg::TBC_FETCH && i_mem_ack && half_r) |=>
        o_br_valid && o_br_target == $past(next_r) + {$past(i_mem_rdata), 1'b0})
        else $error("halfword table target wrong");
    chk_index_scale: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_tb_req.halfword && !i_tb_req.base_is_pc) |=>
        o_mem_addr == $past(i_tb_req.table_base_register)
                      + {$past(i_tb_req.table_index_register[AW-2:0]), 1'b0})
        else $error("halfword index not scaled");
    chk_forward_only: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_br_valid |-> (o_br_target - next_r) <= AW'(32'h0001_FFFE))
        else $error("table branch offset out of forward range");
    chk_pc_base: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_tb_req.base_is_pc && !i_tb_req.halfword) |=>
        o_mem_req && o_mem_addr == $past(i_tb_req.next_addr)
                                   + $past(i_tb_req.table_index_register))
        else $error("pc based table start wrong");
    chk_flags_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (o_mem_req && !i_flags_we) |=> o_flags == $past(o_flags))
        else $error("flags moved during table branch");
    chk_prefix_flags: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_it_valid && !i_flags_we) |=> $stable(o_flags) && o_in_it_block)
        else $error("block prefix disturbed flags");
    chk_short_reach: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_cbr_valid && !o_in_it_block) |=>
        (o_cbr_target - $past(i_cbr.next_addr)) ==
        AW'(signed'($past(i_cbr.offset[tbc_pkg::CBR_SHORT_W-1:0]))))
        else $error("outside block branch reach wrong");
    chk_zero_extend: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state_r == tbc_pkg::TBC_FETCH && i_mem_ack && !half_r) |=>
        (o_br_target - next_r) < AW'(32'h0000_0200))
        else $error("byte entry not zero extended");
    cov_byte_branch: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        take && !i_tb_req.halfword ##[1:20] o_br_valid);
    cov_half_branch: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        take && i_tb_req.halfword ##[1:20] o_br_valid);
    cov_last_in_block: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        take && it_left_r == tbc_pkg::IT_LAST);
    cov_long_reach: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_cbr_valid && o_in_it_block);
endmodule
`default_nettype wire

// ==== sim/tb_tbc_table_branch.sv ====
/*
 * tb_tbc_table_branch: self-checking bench for tbc_table_branch.
 * assumes the core package is compiled first; the bench plays memory and
 * instruction stream, driving at rising edges and sampling at falling ones.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_tbc_table_branch;
    typedef struct packed {
        tbc_pkg::tbc_req_t req;
        logic [15:0]       data;
        logic [3:0]        dly;
        logic [31:0]       addr;
        logic [31:0]       tgt;
        logic              err;
    } tbc_row_t;

    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              tb_valid = 1'b0;
    tbc_pkg::tbc_req_t tb_req = '0;
    logic              ack = 1'b0;
    logic [15:0]       rdata = 16'h0000;
    logic              it_valid = 1'b0;
    logic [2:0]        it_len = 3'h0;
    logic [3:0]        it_cond = 4'h0;
    logic              retire = 1'b0;
    logic              cbr_valid = 1'b0;
    tbc_pkg::tbc_cbr_t cbr = '0;
    logic              flags_we = 1'b0;
    logic [3:0]        flags = 4'h0;
    logic              o_tb_ready, o_mem_req, o_mem_half, o_br_valid, o_usage_err;
    logic              o_in_it_block, o_cbr_valid;
    logic [31:0]       o_mem_addr, o_br_target, o_cbr_target;
    logic [3:0]        o_it_cond, o_flags;
    int                miscompares = 0;
    int                num_checks = 0;
    tbc_row_t          rows [8];

    tbc_table_branch i_dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_tb_valid(tb_valid), .o_tb_ready(o_tb_ready),
        .i_tb_req(tb_req), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
        .o_mem_half(o_mem_half), .i_mem_ack(ack), .i_mem_rdata(rdata),
        .o_br_valid(o_br_valid), .o_br_target(o_br_target), .o_usage_err(o_usage_err),
        .i_it_valid(it_valid), .i_it_len(it_len), .i_it_cond(it_cond), .i_retire(retire),
        .o_in_it_block(o_in_it_block), .o_it_cond(o_it_cond), .i_cbr_valid(cbr_valid),
        .i_cbr(cbr), .o_cbr_valid(o_cbr_valid), .o_cbr_target(o_cbr_target),
        .i_flags_we(flags_we), .i_flags(flags), .o_flags(o_flags)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic tbc_row_t mk(input logic [4:0] k, input logic [31:0] b, i, n,
                                    input logic [15:0] d, input logic [3:0] dl,
                                    input logic [31:0] a, t, input logic e);
        mk.req  = {k, b, i, n};
        mk.data = d;
        mk.dly  = dl;
        mk.addr = a;
        mk.tgt  = t;
        mk.err  = e;
    endfunction

    // one table branch; ack is held back by r.dly cycles to model slow memory
    task automatic tb_run(input tbc_row_t r);
        @(posedge clk);
        tb_valid <= 1'b1;
        tb_req   <= r.req;
        @(posedge clk);
        tb_valid <= 1'b0;
        @(negedge clk);
        chk("usage_err", {31'h0, r.err}, {31'h0, o_usage_err});
        chk("mem_req", 32'h1, {31'h0, o_mem_req});
        chk("mem_addr", r.addr, o_mem_addr);
        chk("mem_half", {31'h0, r.req.halfword}, {31'h0, o_mem_half});
        repeat (r.dly) @(posedge clk);
        @(posedge clk);
        ack   <= 1'b1;
        rdata <= r.data;
        @(posedge clk);
        ack   <= 1'b0;
        rdata <= ~r.data;
        @(negedge clk);
        chk("br_valid", 32'h1, {31'h0, o_br_valid});
        chk("br_target", r.tgt, o_br_target);
        chk("flags", 32'hA, {28'h0, o_flags});
    endtask

    task automatic cbr_run(input logic [20:0] ofs, input logic [31:0] exp);
        @(posedge clk);
        cbr_valid <= 1'b1;
        cbr       <= {ofs, 32'h0000_8000};
        @(posedge clk);
        cbr_valid <= 1'b0;
        @(negedge clk);
        chk("cbr_valid", 32'h1, {31'h0, o_cbr_valid});
        chk("cbr_target", exp, o_cbr_target);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // kind bits: halfword, base_is_pc, base_is_sp, index_is_sp, index_is_pc
        rows[0] = mk(5'h00, 32'h2000, 3, 32'h1004, 16'hAB81, 0, 32'h2003, 32'h1106, 0);
        rows[1] = mk(5'h10, 32'h2000, 3, 32'h1004, 16'hFFFE, 0, 32'h2006, 32'h21000, 0);
        rows[2] = mk(5'h08, 32'h9999, 5, 32'h1004, 16'h0000, 0, 32'h1009, 32'h1004, 0);
        rows[3] = mk(5'h18, 32'h9999, 2, 32'h1004, 16'h0010, 1, 32'h1008, 32'h1024, 0);
        rows[4] = mk(5'h04, 32'h3000, 0, 32'h1004, 16'h0001, 0, 32'h3000, 32'h1006, 1);
        rows[5] = mk(5'h11, 32'h3000, 1, 32'h1004, 16'h8000, 2, 32'h3002, 32'h11004, 1);
        rows[6] = mk(5'h02, 32'h3000, 4, 32'h1004, 16'h00FF, 3, 32'h3004, 32'h1202, 1);
        rows[7] = mk(5'h00, 32'h10, 0, 32'hFFFF_FFF0, 16'h00FF, 0, 32'h10, 32'h1EE, 0);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("rst_ready", 32'h1, {31'h0, o_tb_ready});
        chk("rst_outs", 32'h0, {o_mem_req, o_br_valid, o_usage_err, o_in_it_block, o_flags});
        @(posedge clk);
        flags_we <= 1'b1;
        flags    <= 4'hA;
        @(posedge clk);
        flags_we <= 1'b0;
        @(negedge clk);
        chk("flags_wr", 32'hA, {28'h0, o_flags});
        for (int k = 0; k < 8; k++) begin
            tb_run(rows[k]);
        end
        // two-deep block: a table branch that is not last is flagged
        @(posedge clk);
        it_valid <= 1'b1;
        it_len   <= 3'h2;
        it_cond  <= 4'h1;
        @(posedge clk);
        it_valid <= 1'b0;
        @(negedge clk);
        chk("in_block", 32'h1, {31'h0, o_in_it_block});
        chk("it_cond", 32'h1, {28'h0, o_it_cond});
        chk("flags_it", 32'hA, {28'h0, o_flags});
        tb_run(mk(5'h00, 32'h2000, 0, 32'h1004, 16'h0002, 0, 32'h2000, 32'h1008, 1));
        cbr_run(21'h1FF000, 32'h7000);
        @(posedge clk);
        retire <= 1'b1;
        @(posedge clk);
        retire <= 1'b0;
        tb_run(mk(5'h00, 32'h2000, 0, 32'h1004, 16'h0002, 0, 32'h2000, 32'h1008, 0));
        @(posedge clk);
        retire <= 1'b1;
        @(posedge clk);
        retire <= 1'b0;
        @(negedge clk);
        chk("block_done", 32'h0, {31'h0, o_in_it_block});
        cbr_run(21'h0001F0, 32'h7FF0);
        // an over-long prefix clamps to the limit, so three retires leave one slot
        @(posedge clk);
        it_valid <= 1'b1;
        it_len   <= 3'h7;
        @(posedge clk);
        it_valid <= 1'b0;
        retire   <= 1'b1;
        repeat (3) @(posedge clk);
        retire   <= 1'b0;
        tb_run(mk(5'h00, 32'h2000, 32'h0, 32'h1004, 16'h0002, 4'h0,
                  32'h2000, 32'h1008, 1'h0));
        // reset in the middle of a table fetch and inside a block
        @(posedge clk);
        tb_valid <= 1'b1;
        tb_req   <= rows[0].req;
        @(posedge clk);
        tb_valid <= 1'b0;
        rstn     <= 1'b0;
        repeat (2) @(posedge clk);
        rstn     <= 1'b1;
        @(negedge clk);
        chk("rst2_ready", 32'h1, {31'h0, o_tb_ready});
        chk("rst2_outs", 32'h0, {o_mem_req, o_br_valid, o_usage_err, o_in_it_block, o_flags});
        chk("rst2_target", 32'h0, o_br_target);
        chk("rst2_cond", 32'h0, {28'h0, o_it_cond});
        // reset cleared the flags, so they are rewritten before the next branch
        @(posedge clk);
        flags_we <= 1'b1;
        flags    <= 4'hA;
        @(posedge clk);
        flags_we <= 1'b0;
        tb_run(rows[1]);
        end_sim();
    end

    // whole run is under a hundred cycles; this bound only catches a hang
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
